/* logic/sim_monitor.sv */
// top of the safety input monitor: e-stop and gate monitors, test pulses, apb registers
module sim_monitor #(
	parameter int unsigned TICK_CYCLES = sim_pkg::TICK_CYC
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire sim_pkg::sim_apb_req_t apb_req,
	output sim_pkg::sim_apb_rsp_t      apb_rsp,
	input  wire sim_pkg::sim_contact_t estop_in,
	input  wire sim_pkg::sim_contact_t gate_in,
	output logic                       estop_ok,
	output logic                       gate_ok,
	output logic                       estop_fault,
	output logic                       gate_fault,
	output logic                       test_line_a,
	output logic                       test_line_b,
	output logic                       irq
);
	import sim_pkg::*;

	typedef struct packed {
		sim_cfg_t [1:0] cfg;
		logic [3:0]     mask;
		logic [3:0]     stat;
		sim_mon_t [1:0] mon;
		logic [1:0]     fault_out;
		logic [15:0]    tick_cnt;
		logic           tick;
		sim_tp_t        tp_phase;
		logic [7:0]     tp_ms;
		logic [11:0]    tp_cnt;
		logic           test_a;
		logic           test_b;
		logic           pready;
		logic           pslverr;
		logic [31:0]    prdata;
		logic           irq;
	} sim_state_t;

	sim_state_t   s_reg;
	sim_state_t   s_next;
	sim_contact_t [1:0] cin;
	logic [3:0]   raw_ch;
	logic [3:0]   filt_ch;

	// keep the filter setting inside its legal range
	function automatic logic [7:0] clamp_filter(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v < FILTER_MIN_MS) begin
			r = FILTER_MIN_MS;
		end else if (v > FILTER_MAX_MS) begin
			r = FILTER_MAX_MS;
		end
		return r;
	endfunction : clamp_filter

	// second channel as a "safe" level: single e-stop mirrors the first, mixed gate is inverted
	function automatic logic norm_second(input logic is_gate, input logic second_type,
			input logic f1, input logic f2);
		logic b;
		b = f2;
		if (!is_gate && !second_type) begin
			b = f1;
		end else if (is_gate && second_type) begin
			b = !f2;
		end
		return b;
	endfunction : norm_second

	// one step of a monitor: reset acceptance, simultaneity, start-up test and lockout
	function automatic sim_mon_t mon_step(input sim_mon_t m, input sim_cfg_t c, input logic a,
			input logic b, input logic rst_in, input logic short_hit, input logic tick);
		sim_mon_t n;
		logic     safe;
		logic     rise;
		logic     rst_ok;
		logic     sim_err;
		n          = m;
		safe       = a & b;
		rise       = rst_in && !m.rst_prev;
		n.rst_prev = rst_in;
		if (rise) begin
			n.arm = 1'b1;
		end
		// manual takes the rising edge, monitored the fall after a rise
		if (c.reset_monitored) begin
			rst_ok = m.arm && m.rst_prev && !rst_in;
		end else begin
			rst_ok = rise;
		end
		if (rst_ok) begin
			n.arm = 1'b0;
		end
		// count the ticks the two channels disagree
		if (a == b) begin
			n.disc_cnt = 8'h00;
		end else if (tick && m.disc_cnt != 8'hFF) begin
			n.disc_cnt = m.disc_cnt + 8'h01;
		end
		sim_err = c.simul_en && (a != b) && (m.disc_cnt > c.simul_ms);
		case (m.state)
			// stay here until the filtered contacts first read safe: this gives software time to
			// load the start-up option, and the power-on open level does not count as the test
			ST_WAIT_TEST: begin
				if (safe) begin
					n.seen_safe = 1'b1;
				end
				if (!c.startup_en) begin
					if (safe) begin
						n.state = c.reset_en ? ST_LOCKED : ST_RUN;
					end
				end else if (!safe && m.seen_safe) begin
					n.seen_unsafe = 1'b1;
				end else if (safe && m.seen_unsafe) begin
					n.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!safe && c.reset_en) begin
					n.state = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				if (!c.reset_en) begin
					n.state = ST_RUN;
				end else if (safe && rst_ok) begin
					n.state = ST_RUN;
				end
			end
			default: begin
				if (c.reset_en && rst_ok) begin
					n.state = safe ? ST_RUN : ST_LOCKED;
				end
			end
		endcase
		if (m.state != ST_FAULT && (sim_err || short_hit)) begin
			n.state = ST_FAULT;
		end
		n.ok    = (n.state == ST_RUN) && safe;
		n.fault = (n.state == ST_FAULT);
		return n;
	endfunction : mon_step

	// contact lines in one array: estop first, gate second
	assign cin    = {gate_in, estop_in};
	assign raw_ch = {gate_in.second_contact_channel, gate_in.first_contact_channel,
		estop_in.second_contact_channel, estop_in.first_contact_channel};

	// one debounce filter per contact line
	for (genvar gi = 0; gi < 4; gi++) begin : g_deb
		sim_debounce u_deb (
			.pclk      (pclk),
			.presetn   (presetn),
			.tick      (s_reg.tick),
			.din       (raw_ch[gi]),
			.filter_ms (clamp_filter(s_reg.cfg[gi / 2].filter_ms)),
			.dout      (filt_ch[gi])
		);
	end

	// next state of the whole block
	always_comb begin
		logic       any_test;
		logic       last_low;
		logic [1:0] short_hit;
		logic       done;
		logic       rc;
		logic [3:0] ev;
		logic       hit;
		logic [31:0] rd;
		s_next    = s_reg;
		any_test  = 1'b0;
		last_low  = 1'b0;
		done      = 1'b0;
		rc        = 1'b0;
		short_hit = 2'b00;
		ev        = 4'h0;
		hit       = 1'b0;
		rd        = 32'h0000_0000;

		// millisecond tick
		s_next.tick = 1'b0;
		if (s_reg.tick_cnt == 16'(TICK_CYCLES - 1)) begin
			s_next.tick_cnt = 16'h0000;
			s_next.tick     = 1'b1;
		end else begin
			s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
		end

		// test pulses: line a low, then line b low, once each period
		any_test = s_reg.cfg[0].test_en | s_reg.cfg[1].test_en;
		last_low = (s_reg.tp_cnt == 12'(TEST_LOW_CYC - 1));
		case (s_reg.tp_phase)
			TP_IDLE: begin
				if (s_reg.tick) begin
					if (s_reg.tp_ms == 8'(TEST_PERIOD_MS - 1)) begin
						s_next.tp_ms = 8'h00;
						if (any_test) begin
							s_next.tp_phase = TP_A;
							s_next.tp_cnt   = 12'h000;
						end
					end else begin
						s_next.tp_ms = s_reg.tp_ms + 8'h01;
					end
				end
			end
			TP_A: begin
				s_next.tp_cnt = s_reg.tp_cnt + 12'h001;
				if (last_low) begin
					// a first channel still high while its feed is low is shorted elsewhere
					for (int i = 0; i < 2; i++) begin
						short_hit[i] = s_reg.cfg[i].test_en & cin[i].first_contact_channel;
					end
					s_next.tp_phase = TP_B;
					s_next.tp_cnt   = 12'h000;
				end
			end
			default: begin
				s_next.tp_cnt = s_reg.tp_cnt + 12'h001;
				if (last_low) begin
					for (int i = 0; i < 2; i++) begin
						short_hit[i] = s_reg.cfg[i].test_en & cin[i].second_contact_channel;
					end
					s_next.tp_phase = TP_IDLE;
				end
			end
		endcase
		s_next.test_a = (s_next.tp_phase != TP_A);
		s_next.test_b = (s_next.tp_phase != TP_B);

		// both monitors; the reset channel follows the two contact channels
		for (int i = 0; i < 2; i++) begin
			s_next.mon[i] = mon_step(s_reg.mon[i], s_reg.cfg[i], filt_ch[2 * i],
				norm_second(i == 1, s_reg.cfg[i].second_type, filt_ch[2 * i], filt_ch[2 * i + 1]),
				cin[i].reset_channel, short_hit[i], s_reg.tick);
			s_next.fault_out[i] = s_next.mon[i].fault & s_reg.cfg[i].err_out_en;
		end
		ev[EV_ESTOP_DROP]  = s_reg.mon[0].ok & !s_next.mon[0].ok;
		ev[EV_GATE_DROP]   = s_reg.mon[1].ok & !s_next.mon[1].ok;
		ev[EV_ESTOP_FAULT] = !s_reg.mon[0].fault & s_next.mon[0].fault;
		ev[EV_GATE_FAULT]  = !s_reg.mon[1].fault & s_next.mon[1].fault;

		// read data for the access phase
		if (apb_req.paddr == ADDR_ESTOP_CFG) begin
			hit = 1'b1;
			rd  = s_reg.cfg[0];
		end else if (apb_req.paddr == ADDR_GATE_CFG) begin
			hit = 1'b1;
			rd  = s_reg.cfg[1];
		end else if (apb_req.paddr == ADDR_STATUS) begin
			hit = 1'b1;
			rd  = {24'h00_0000, s_reg.mon[1].state, s_reg.mon[0].state,
				s_reg.mon[1].fault, s_reg.mon[0].fault, s_reg.mon[1].ok, s_reg.mon[0].ok};
		end else if (apb_req.paddr == ADDR_IRQ_STAT) begin
			hit = 1'b1;
			rd  = {28'h000_0000, s_reg.stat};
		end else if (apb_req.paddr == ADDR_IRQ_MASK) begin
			hit = 1'b1;
			rd  = {28'h000_0000, s_reg.mask};
		end

		// one wait state, then the transfer completes
		s_next.pready  = 1'b0;
		s_next.pslverr = 1'b0;
		if (apb_req.psel && apb_req.penable && !s_reg.pready) begin
			s_next.pready  = 1'b1;
			s_next.pslverr = !hit;
			s_next.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd;
		end
		done = apb_req.psel && apb_req.penable && s_reg.pready;
		rc   = done && !apb_req.pwrite && !s_reg.pslverr && (apb_req.paddr == ADDR_IRQ_STAT);
		if (done && apb_req.pwrite) begin
			if (apb_req.paddr == ADDR_ESTOP_CFG) begin
				s_next.cfg[0] = {8'h00, apb_req.pwdata[23:8], 1'b0, apb_req.pwdata[6:0]};
			end else if (apb_req.paddr == ADDR_GATE_CFG) begin
				s_next.cfg[1] = {8'h00, apb_req.pwdata[23:8], 1'b0, apb_req.pwdata[6:0]};
			end else if (apb_req.paddr == ADDR_IRQ_MASK) begin
				s_next.mask = apb_req.pwdata[3:0];
			end
		end

		// sticky events; a read clears only the bits it returned, new events win
		s_next.stat = (s_reg.stat & ~(rc ? s_reg.prdata[3:0] : 4'h0)) | ev;
		s_next.irq  = |(s_next.stat & s_next.mask);
	end

	// single state register of the block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg          <= '0;
			s_reg.cfg[0]   <= CFG_RESET;
			s_reg.cfg[1]   <= CFG_RESET;
			s_reg.mask     <= MASK_RESET;
			s_reg.tp_phase <= TP_IDLE;
			s_reg.test_a   <= 1'b1;
			s_reg.test_b   <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state register
	assign apb_rsp     = {s_reg.pready, s_reg.pslverr, s_reg.prdata};
	assign estop_ok    = s_reg.mon[0].ok;
	assign gate_ok     = s_reg.mon[1].ok;
	assign estop_fault = s_reg.fault_out[0];
	assign gate_fault  = s_reg.fault_out[1];
	assign test_line_a = s_reg.test_a;
	assign test_line_b = s_reg.test_b;
	assign irq         = s_reg.irq;

endmodule : sim_monitor

/* logic/sim_pkg.sv */
// constants, register map and carrier types of the safety input monitor
//
// What this block does
// - e-stop output false while button pressed, true while released
// - e-stop takes one normally-closed channel or two normally-closed channels
// - with reset enabled each e-stop activation needs a reset; else output follows input
// - manual reset on a 0-to-1 edge; monitored reset on 0-to-1 then back to 0
// - reset signal comes from the channel right after the contact channels
// - test pulses go to the contacts and their return reveals line shorts
// - start-up test holds e-stop output false until one press and release after power-on
// - each contact input is debounced with a 3 to 250 ms filter
// - simultaneity check requires both channels to switch within a set millisecond window
// - error output, when enabled, reports any fault the monitor detects
// - gate output 0 while the gate is open, 1 while closed
// - gate takes two normally-closed contacts or one normally-open plus one normally-closed
// - with reset enabled each gate opening needs a reset; else output follows contacts
// - start-up test holds gate output false until the gate has been opened once
package sim_pkg;

	// clock and timing
	localparam int unsigned CLK_MHZ        = 25;
	localparam int unsigned TICK_US        = 1000;
	localparam int unsigned TICK_CYC       = TICK_US * CLK_MHZ;
	localparam int unsigned TEST_LOW_US    = 100;
	localparam int unsigned TEST_LOW_CYC   = TEST_LOW_US * CLK_MHZ;
	localparam int unsigned TEST_PERIOD_MS = 50;
	localparam logic [7:0]  FILTER_MIN_MS  = 8'h03;
	localparam logic [7:0]  FILTER_MAX_MS  = 8'hFA;

	// register byte offsets
	localparam logic [31:0] ADDR_ESTOP_CFG = 32'h0000_0000;
	localparam logic [31:0] ADDR_GATE_CFG  = 32'h0000_0004;
	localparam logic [31:0] ADDR_STATUS    = 32'h0000_0008;
	localparam logic [31:0] ADDR_IRQ_STAT  = 32'h0000_000C;
	localparam logic [31:0] ADDR_IRQ_MASK  = 32'h0000_0010;

	// reset values
	localparam logic [31:0] CFG_RESET      = 32'h0000_0A00;
	localparam logic [3:0]  MASK_RESET     = 4'h0;

	// event bit positions in the interrupt status and mask
	localparam int unsigned EV_ESTOP_DROP  = 0;
	localparam int unsigned EV_GATE_DROP   = 1;
	localparam int unsigned EV_ESTOP_FAULT = 2;
	localparam int unsigned EV_GATE_FAULT  = 3;

	// configuration word of one monitor, same layout for both
	typedef struct packed {
		logic [7:0] spare_hi;
		logic [7:0] simul_ms;
		logic [7:0] filter_ms;
		logic       spare_lo;
		logic       err_out_en;
		logic       simul_en;
		logic       startup_en;
		logic       test_en;
		logic       reset_monitored;
		logic       reset_en;
		logic       second_type;
	} sim_cfg_t;

	typedef enum logic [1:0] {
		ST_WAIT_TEST = 2'b00,
		ST_RUN       = 2'b01,
		ST_LOCKED    = 2'b11,
		ST_FAULT     = 2'b10
	} sim_mon_state_t;

	typedef enum logic [1:0] {
		TP_IDLE = 2'b00,
		TP_A    = 2'b01,
		TP_B    = 2'b11
	} sim_tp_t;

	typedef struct packed {
		sim_mon_state_t state;
		logic           seen_unsafe;
		logic           seen_safe;
		logic           arm;
		logic           rst_prev;
		logic [7:0]     disc_cnt;
		logic           ok;
		logic           fault;
	} sim_mon_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic       level;
	} sim_deb_t;

	typedef struct packed {
		logic first_contact_channel;
		logic second_contact_channel;
		logic reset_channel;
	} sim_contact_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} sim_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} sim_apb_rsp_t;

endpackage : sim_pkg

/* logic/sim_debounce.sv */
// debounce filter for one contact line, counted in millisecond ticks
module sim_debounce (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick,
	input  wire logic       din,
	input  wire logic [7:0] filter_ms,
	output logic            dout
);
	import sim_pkg::*;

	sim_deb_t deb_reg;
	sim_deb_t deb_next;

	// restart the count on any return to the held level; the first tick only starts the count,
	// so a new level is taken after at least filter_ms whole ticks and never a tick early
	always_comb begin
		deb_next = deb_reg;
		if (din == deb_reg.level) begin
			deb_next.cnt = 8'h00;
		end else if (tick) begin
			if (deb_reg.cnt >= filter_ms) begin
				deb_next.level = din;
				deb_next.cnt   = 8'h00;
			end else begin
				deb_next.cnt = deb_reg.cnt + 8'h01;
			end
		end
	end

	// state register, contacts taken as open at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deb_reg <= '0;
		end else begin
			deb_reg <= deb_next;
		end
	end

	assign dout = deb_reg.level;

endmodule : sim_debounce

/* test/sim_checker.sv */
// assertion checker bound to the safety input monitor ports
module sim_checker
	import sim_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire sim_pkg::sim_apb_req_t apb_req,
	input wire sim_pkg::sim_apb_rsp_t apb_rsp,
	input wire sim_pkg::sim_contact_t estop_in,
	input wire sim_pkg::sim_contact_t gate_in,
	input wire logic                  estop_ok,
	input wire logic                  gate_ok,
	input wire logic                  estop_fault,
	input wire logic                  gate_fault,
	input wire logic                  test_line_a,
	input wire logic                  test_line_b,
	input wire logic                  irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] hi_cnt;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles that e-stop channel one has stayed closed, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_cnt <= '0;
		else if (!estop_in.first_contact_channel)
			hi_cnt <= '0;
		else if (hi_cnt != 16'hFFFF)
			hi_cnt <= hi_cnt + 16'h0001;
	end
	// bus answer timing
	property p_ready_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_ready_answer; apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready; endproperty
	a_ready_answer: assert property (p_ready_answer) else $error("pready late");
	property p_err_zero; apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0000_0000; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error response malformed");
	// monitor outputs against their contacts and faults, test line order, irq release
	property p_estop_rise; $rose(estop_ok) |-> $past(estop_in.first_contact_channel); endproperty
	a_estop_rise: assert property (p_estop_rise) else $error("estop true while pressed");
	property p_estop_filter; $rose(estop_ok) |-> hi_cnt >= 16'(3 * TICK_CYCLES); endproperty
	a_estop_filter: assert property (p_estop_filter) else $error("estop rose inside filter");
	property p_gate_rise; $rose(gate_ok) |-> $past(gate_in.first_contact_channel); endproperty
	a_gate_rise: assert property (p_gate_rise) else $error("gate true while open");
	property p_fault_false; (estop_fault |-> !estop_ok) and (gate_fault |-> !gate_ok); endproperty
	a_fault_false: assert property (p_fault_false) else $error("output true in fault");
	property p_lines_apart; !(!test_line_a && !test_line_b); endproperty
	a_lines_apart: assert property (p_lines_apart) else $error("both test lines low");
	property p_line_order; $fell(test_line_b) |-> !$past(test_line_a); endproperty
	a_line_order: assert property (p_line_order) else $error("line b pulse not after a");
	property p_irq_fall; $fell(irq) |-> $past(apb_req.psel && apb_req.penable); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
	// main scenarios reached
	c_fault: cover property ($rose(estop_fault));
	c_gate: cover property ($rose(gate_ok));
	c_irq: cover property ($rose(irq));
endmodule : sim_checker

bind sim_monitor sim_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk, .presetn, .apb_req, .apb_rsp,
	.estop_in, .gate_in, .estop_ok, .gate_ok, .estop_fault, .gate_fault, .test_line_a, .test_line_b, .irq);

/* test/sim_contacts.sv */
// contact model: e-stop button and gate contacts wired through the test lines
module sim_contacts
	import sim_pkg::*;
(
	input wire logic              test_line_a,
	input wire logic              test_line_b,
	input wire logic              e_c1,
	input wire logic              e_c2,
	input wire logic              e_rst,
	input wire logic              g_cl,
	input wire logic              g_mix,
	input wire logic              g_rst,
	input wire logic              sh_a,
	output sim_pkg::sim_contact_t estop_in,
	output sim_pkg::sim_contact_t gate_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// a closed contact returns its test line; a short holds channel one at supply
	assign estop_in = {sh_a | (e_c1 & test_line_a), e_c2 & test_line_b, e_rst};
	// mixed gate: closed-type contact on channel one, open-type on channel two
	assign gate_in  = {g_cl & test_line_a, (g_mix ? !g_cl : g_cl) & test_line_b, g_rst};
endmodule : sim_contacts

/* test/sim_monitor_tb.sv */
// self-checking testbench of the safety input monitor
module sim_monitor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sim_pkg::*;
	logic         pclk = 0;
	logic         presetn = 0;
	sim_apb_req_t apb_req = '0;
	sim_apb_rsp_t apb_rsp;
	sim_contact_t estop_in, gate_in;
	logic estop_ok, gate_ok, estop_fault, gate_fault, test_line_a, test_line_b, irq;
	logic e_c1 = 1, e_c2 = 1, e_rst = 0, g_cl = 1, g_mix = 0, g_rst = 0, sh_a = 0;
	logic [31:0] rd;
	logic er, hit;
	logic [3:0] obs;
	int n, errors = 0, samples_checked = 0;
	assign obs = {irq, estop_fault, gate_ok, estop_ok};
	// 25 MHz clock
	always #20 pclk = ~pclk;
	sim_monitor #(.TICK_CYCLES(10)) DUT (.pclk, .presetn, .apb_req, .apb_rsp, .estop_in, .gate_in,
		.estop_ok, .gate_ok, .estop_fault, .gate_fault, .test_line_a, .test_line_b, .irq);
	sim_contacts PARTNER (.test_line_a, .test_line_b, .e_c1, .e_c2, .e_rst, .g_cl, .g_mix, .g_rst,
		.sh_a, .estop_in, .gate_in);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (apb_rsp.pready !== 1'b1 && k < 20);
		rd = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req <= '0;
		check(apb_rsp.pready, 1'b1, "pready");
	endtask : apb
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, '0);
		check(rd, exp, what);
	endtask : rdchk
	// wait for one observed output to reach a level, counting cycles
	task automatic wt(input int s, input logic v, input int lim);
		n = 0;
		hit = 0;
		while (!hit && n < lim) begin
			@(posedge pclk);
			n++;
			hit = (obs[s] === v);
		end
	endtask : wt
	task automatic t_regs;
		check({estop_ok, gate_ok, irq, test_line_a}, 4'b0001, "reset outputs");
		rdchk(ADDR_ESTOP_CFG, CFG_RESET, "estop cfg");
		rdchk(ADDR_GATE_CFG, CFG_RESET, "gate cfg");
		rdchk(ADDR_IRQ_MASK, 32'h0000_0000, "mask");
		apb(1'b0, 32'h0000_0014, '0);
		check({er, rd[0]}, 2'b10, "unmapped");
		apb(1'b1, ADDR_ESTOP_CFG, 32'hFF00_0A80);
		rdchk(ADDR_ESTOP_CFG, CFG_RESET, "spare bits");
	endtask : t_regs
	task automatic t_follow;
		apb(1'b1, ADDR_ESTOP_CFG, 32'h0000_0300);
		wt(0, 1'b1, 200);
		check(hit, 1'b1, "released");
		e_c1 <= 1'b0;
		wt(0, 1'b0, 100);
		check({hit, n >= 30 && n <= 45}, 2'b11, "press delay");
		e_c1 <= 1'b1;
		wt(0, 1'b1, 100);
		// a bounce shorter than the filter and an idle second channel change nothing
		e_c1 <= 1'b0;
		e_c2 <= 1'b0;
		repeat (20) @(posedge pclk);
		e_c1 <= 1'b1;
		wt(0, 1'b0, 80);
		check(hit, 1'b0, "bounce");
		e_c2 <= 1'b1;
	endtask : t_follow
	task automatic t_reset(input logic [31:0] cfg, input logic mon);
		apb(1'b1, ADDR_ESTOP_CFG, cfg);
		e_c1 <= 1'b0;
		wt(0, 1'b0, 100);
		e_c1 <= 1'b1;
		wt(0, 1'b1, 80);
		check(hit, 1'b0, "locked");
		e_rst <= 1'b1;
		wt(0, 1'b1, 5);
		check(hit, !mon, "reset rise");
		e_rst <= 1'b0;
		wt(0, 1'b1, 5);
		check(hit, 1'b1, "reset done");
	endtask : t_reset
	task automatic t_irq;
		apb(1'b1, ADDR_ESTOP_CFG, 32'h0000_0300);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
		apb(1'b0, ADDR_IRQ_STAT, '0);
		wt(3, 1'b0, 5);
		e_c1 <= 1'b0;
		wt(3, 1'b1, 100);
		check(hit, 1'b1, "irq raised");
		rdchk(ADDR_IRQ_STAT, 32'h0000_0001, "irq stat");
		wt(3, 1'b0, 5);
		check(hit, 1'b1, "irq cleared");
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
		e_c1 <= 1'b1;
		wt(0, 1'b1, 100);
		e_c1 <= 1'b0;
		wt(3, 1'b1, 100);
		check(hit, 1'b0, "masked");
		rdchk(ADDR_IRQ_STAT, 32'h0000_0001, "masked event");
		e_c1 <= 1'b1;
		wt(0, 1'b1, 100);
	endtask : t_irq
	task automatic t_gate;
		check(gate_ok, 1'b1, "gate closed");
		g_cl <= 1'b0;
		wt(1, 1'b0, 200);
		check(hit, 1'b1, "gate open");
		apb(1'b1, ADDR_GATE_CFG, 32'h0000_0303);
		g_mix <= 1'b1;
		g_cl <= 1'b1;
		wt(1, 1'b1, 80);
		check(hit, 1'b0, "gate locked");
		g_rst <= 1'b1;
		wt(1, 1'b1, 5);
		check(hit, 1'b1, "gate reset");
		g_rst <= 1'b0;
	endtask : t_gate
	task automatic t_simul;
		apb(1'b1, ADDR_ESTOP_CFG, 32'h0002_0363);
		e_c1 <= 1'b0;
		wt(2, 1'b1, 200);
		check({hit, n >= 50 && n <= 100}, 2'b11, "simul fault");
		e_c1 <= 1'b1;
		wt(0, 1'b1, 80);
		check(hit, 1'b0, "fault holds");
		check(gate_fault, 1'b0, "gate no fault");
		rdchk(ADDR_STATUS, 32'h0000_0066, "status in fault");
		rdchk(ADDR_IRQ_STAT, 32'h0000_0007, "events");
		e_rst <= 1'b1;
		wt(2, 1'b0, 5);
		check(hit, 1'b1, "fault cleared");
		e_rst <= 1'b0;
	endtask : t_simul
	task automatic t_test;
		apb(1'b1, ADDR_ESTOP_CFG, 32'h0000_0348);
		wt(2, 1'b1, 6000);
		check(hit, 1'b0, "clean pulses");
		sh_a <= 1'b1;
		wt(2, 1'b1, 6000);
		check(hit, 1'b1, "short found");
	endtask : t_test
	// mid-run reset: idle outputs, then each output waits for one unsafe-safe cycle
	task automatic t_startup;
		presetn <= 1'b0;
		sh_a    <= 1'b0;
		g_mix   <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check({estop_ok, gate_ok, estop_fault, gate_fault, irq, test_line_a, test_line_b, apb_rsp.pready},
			8'h06, "reset idle");
		@(posedge pclk);
		check({estop_ok, gate_ok, estop_fault, gate_fault, irq, test_line_a, test_line_b, apb_rsp.pready},
			8'h06, "first edge");
		apb(1'b1, ADDR_ESTOP_CFG, 32'h0000_0310);
		apb(1'b1, ADDR_GATE_CFG, 32'h0000_0310);
		wt(0, 1'b1, 200);
		check({hit, gate_ok}, 2'b00, "startup holds");
		e_c1 <= 1'b0;
		g_cl <= 1'b0;
		repeat (60) @(posedge pclk);
		e_c1 <= 1'b1;
		g_cl <= 1'b1;
		wt(0, 1'b1, 100);
		check(hit, 1'b1, "estop startup done");
		wt(1, 1'b1, 20);
		check(hit, 1'b1, "gate startup done");
	endtask : t_startup
	task automatic summarize;
		$display("errors %0d checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	// watchdog against a hung wait
	initial begin
		repeat (40000) @(posedge pclk);
		errors++;
		$display("ERROR t=%0t watchdog", $time);
		summarize();
	end
	// reset, then the scenarios in order
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_follow();
		t_reset(32'h0000_0302, 1'b0);
		t_reset(32'h0000_0306, 1'b1);
		t_irq();
		t_gate();
		t_simul();
		t_test();
		t_startup();
		summarize();
	end
endmodule : sim_monitor_tb
